// File: core/pcx_port_io.sv
// port side of the bus-linked expander: register file, capture, transmit sequencing, pin muxing
//
// Summary of operation
// - sixteen pins, each configured over the bus
// - remote poll answered with input register frame
// - selected pin edges send input frame unprompted
// - write frame loads output data register
// - output bit driven only when enable set
// - byte one address, bytes two-three contents
// - writes to read-only registers discarded
// - conversion result supplied over the link
// - analog function per pin from configuration
// - first transmit pin pulls low when dominant
// - second drives high; floats recessive/mode two
// - internal oscillator: reset pin active high
// - external oscillator: select pin is reset_n
// - external oscillator: pin zero is clock
// - pins zero-three sampled as identifier; bit zero reads 0 in external mode
// - pulse outputs b on pin four, a ten
// - comparator outputs on pins seven, eight, nine
// - pin fifteen comparator in, feedback out extra
// - input snapshot taken after control field sent
// - outputs update once frame checked valid
// - rise/fall enables combine per pin
// - sign-on frame after calibration completes
`include "pcx_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module pcx_port_io #(
	parameter int N = `PCX_NUM_PINS
) (
	input  wire logic                  clk,                    // system clock, 100 MHz
	input  wire logic                  rst_b,                  // async reset, active low
	input  wire logic [N-1:0]          port_in,                // raw pin levels
	output logic      [N-1:0]          port_out,               // pin drive values
	output logic      [N-1:0]          port_oe,                // pin drive enables
	input  wire logic                  rx_valid,               // checked frame pulse
	input  wire logic                  rx_remote,              // frame is a remote poll
	input  wire logic [7:0]            rx_byte1,               // register address
	input  wire logic [7:0]            rx_byte2,               // contents high byte
	input  wire logic [7:0]            rx_byte3,               // contents low byte
	input  wire logic                  calibrated,             // bit timing calibrated pulse
	output logic                       tx_req,                 // frame wanted
	output logic                       tx_kind,                // 0 input frame, 1 result
	output logic      [15:0]           tx_data,                // frame contents
	input  wire logic                  tx_ctrl_sent,           // control field sent pulse
	input  wire logic                  tx_done,                // frame finished pulse
	input  wire logic                  tx_dominant,            // engine bit is dominant
	input  wire logic                  bus_mode2,              // bus mode 2 active
	output logic                       bus_tx_pull_low_o,      // first transmit pin value
	output logic                       bus_tx_pull_low_oe,     // first transmit pin enable
	output logic                       bus_tx_drive_high_o,    // second transmit pin value
	output logic                       bus_tx_drive_high_oe,   // second transmit pin enable
	input  wire logic                  ext_osc_strap,          // oscillator mode strap
	input  wire logic                  reset_pin,              // dedicated reset pin
	input  wire logic                  osc_select_or_reset_n,  // mode select / reset pin
	output logic                       dev_reset,              // device reset request
	output logic                       port_zero_or_clock,     // pin zero routed as clock
	output logic      [3:0]            id_bits,                // identifier bits
	input  wire logic                  pulse_mod_out_a,        // pulse generator a
	input  wire logic                  pulse_mod_out_b,        // pulse generator b
	input  wire logic [2:0]            cmp_in,                 // comparators 1,2,3
	input  wire logic                  conv_feedback,          // converter feedback source
	output logic                       converter_feedback_out, // extra feedback pin
	output logic                       conv_cmp_in,            // pin fifteen to converter
	output logic      [15:0]           analog_cfg,             // analog configuration
	output logic      [15:0]           pm_a_level,             // pulse a setting
	output logic      [15:0]           pm_b_level,             // pulse b setting
	output logic                       adc_start,              // conversion start pulse
	input  wire logic                  adc_done,               // conversion finished pulse
	input  wire logic [9:0]            adc_result              // conversion result
);
	import pcx_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// pin and strap synchronisation

	logic [N-1:0] pin_s;
	logic [1:0]   rst_s;
	logic         ext_osc_r, strap_done_r;

	pcx_pin_sync #(.W(N)) u_pin_sync (
		.clk      (clk),
		.rst_b    (rst_b),
		.pin_in   (port_in),
		.stable_o (pin_s)
	);

	pcx_pin_sync #(.W(2)) u_rst_sync (
		.clk      (clk),
		.rst_b    (rst_b),
		.pin_in   ({osc_select_or_reset_n, reset_pin}),
		.stable_o (rst_s)
	);

	// strap is caught on the first clock after release, never under reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ext_osc_r    <= 1'b0;
			strap_done_r <= 1'b0;
		end else if (!strap_done_r) begin
			ext_osc_r    <= ext_osc_strap;
			strap_done_r <= 1'b1;
		end
	end

	pcx_bus_drv u_bus_drv (
		.clk                  (clk),
		.rst_b                (rst_b),
		.tx_dominant          (tx_dominant),
		.bus_mode2            (bus_mode2),
		.ext_osc              (ext_osc_r),
		.reset_pin_s          (rst_s[0]),
		.osc_sel_s            (rst_s[1]),
		.bus_tx_pull_low_o    (bus_tx_pull_low_o),
		.bus_tx_pull_low_oe   (bus_tx_pull_low_oe),
		.bus_tx_drive_high_o  (bus_tx_drive_high_o),
		.bus_tx_drive_high_oe (bus_tx_drive_high_oe),
		.dev_reset_o          (dev_reset)
	);

	// pin zero is the clock in external mode, so it leaves the identifier
	assign port_zero_or_clock = ext_osc_r;
	assign id_bits = {pin_s[3:1], pin_s[0] & !ext_osc_r};
	assign converter_feedback_out = conv_feedback;
	assign conv_cmp_in = pin_s[`PCX_PIN_CMPIN];

	////////////////////////////////////////////////////////////////////////////////
	// register file written by checked frames

	logic [15:0]  rise_r, fall_r, dout_r, oen_r, acfg_r, pma_r, pmb_r;
	logic [15:0]  rise_nxt, fall_nxt, dout_nxt, oen_nxt, acfg_nxt, pma_nxt, pmb_nxt;
	logic [15:0]  wr_val;
	logic         wr;
	logic         adc_clear;

	assign wr     = rx_valid && !rx_remote;
	assign wr_val = {rx_byte2, rx_byte3};

	// unknown and read-only addresses fall through with nothing changed
	always_comb begin
		rise_nxt = rise_r;
		fall_nxt = fall_r;
		dout_nxt = dout_r;
		oen_nxt  = oen_r;
		acfg_nxt = acfg_r;
		pma_nxt  = pma_r;
		pmb_nxt  = pmb_r;
		if (adc_clear) begin
			acfg_nxt[`PCX_ACFG_ADC_BIT] = 1'b0;
		end
		if (wr) begin
			case (rx_byte1)
				`PCX_ADDR_RISE: rise_nxt = wr_val;
				`PCX_ADDR_FALL: fall_nxt = wr_val;
				`PCX_ADDR_DOUT: dout_nxt = wr_val;
				`PCX_ADDR_OEN:  oen_nxt  = wr_val;
				`PCX_ADDR_ACFG: acfg_nxt = wr_val & `PCX_ACFG_WMASK;
				`PCX_ADDR_PMA:  pma_nxt  = wr_val & `PCX_PM_WMASK;
				`PCX_ADDR_PMB:  pmb_nxt  = wr_val & `PCX_PM_WMASK;
				default: ;
			endcase
		end
	end

	// device reset pin clears the configuration like a power-up
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rise_r <= `PCX_RST_VAL;
			fall_r <= `PCX_RST_VAL;
			dout_r <= `PCX_RST_VAL;
			oen_r  <= `PCX_RST_VAL;
			acfg_r <= `PCX_RST_VAL;
			pma_r  <= `PCX_RST_VAL;
			pmb_r  <= `PCX_RST_VAL;
		end else if (dev_reset) begin
			rise_r <= `PCX_RST_VAL;
			fall_r <= `PCX_RST_VAL;
			dout_r <= `PCX_RST_VAL;
			oen_r  <= `PCX_RST_VAL;
			acfg_r <= `PCX_RST_VAL;
			pma_r  <= `PCX_RST_VAL;
			pmb_r  <= `PCX_RST_VAL;
		end else begin
			rise_r <= rise_nxt;
			fall_r <= fall_nxt;
			dout_r <= dout_nxt;
			oen_r  <= oen_nxt;
			acfg_r <= acfg_nxt;
			pma_r  <= pma_nxt;
			pmb_r  <= pmb_nxt;
		end
	end

	assign analog_cfg = acfg_r;
	assign pm_a_level = pma_r;
	assign pm_b_level = pmb_r;
	// one pulse per write with the start bit set, even if it is already set
	assign adc_start  = wr && rx_byte1 == `PCX_ADDR_ACFG && wr_val[`PCX_ACFG_ADC_BIT] && !dev_reset;

	////////////////////////////////////////////////////////////////////////////////
	// pin drive: data or alternate function, always gated by the enable

	logic [N-1:0] pout_r, pout_nxt, poe_r, poe_nxt;

	always_comb begin
		pout_nxt = dout_r;
		if (acfg_r[`PCX_ACFG_M1_BIT]) pout_nxt[`PCX_PIN_PMB] = pulse_mod_out_b;
		if (acfg_r[`PCX_ACFG_M2_BIT]) pout_nxt[`PCX_PIN_PMA] = pulse_mod_out_a;
		if (acfg_r[`PCX_ACFG_OC1_BIT]) pout_nxt[`PCX_PIN_CMP1] = cmp_in[0];
		if (acfg_r[`PCX_ACFG_OC2_BIT]) pout_nxt[`PCX_PIN_CMP2] = cmp_in[1];
		if (acfg_r[`PCX_ACFG_OC3_BIT]) pout_nxt[`PCX_PIN_CMP3] = cmp_in[2];
		poe_nxt = oen_r;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pout_r <= '0;
			poe_r  <= '0;
		end else begin
			pout_r <= pout_nxt;
			poe_r  <= poe_nxt;
		end
	end

	assign port_out = pout_r;
	assign port_oe  = poe_r;

	////////////////////////////////////////////////////////////////////////////////
	// edge capture and transmit sequencing

	logic [N-1:0]     prev_r;
	logic             edge_hit;
	logic             in_pend_r, in_pend_nxt, adc_pend_r, adc_pend_nxt;
	logic             kind_r, kind_nxt;
	logic [15:0]      data_r, data_nxt;
	logic [9:0]       res_r, res_nxt;
	pcx_tx_state_type st_r, st_nxt;

	// per-pin enables pick rising, falling or both
	assign edge_hit = |((pin_s & ~prev_r & rise_r[N-1:0]) | (~pin_s & prev_r & fall_r[N-1:0]));

	// the snapshot waits for the control field so inputs have time to settle
	always_comb begin
		st_nxt       = st_r;
		kind_nxt     = kind_r;
		data_nxt     = data_r;
		res_nxt      = adc_done ? adc_result : res_r;
		adc_clear    = 1'b0;
		// new requests win over the clear of the same cycle
		in_pend_nxt  = in_pend_r;
		adc_pend_nxt = adc_pend_r;
		unique case (st_r)
			PCX_IDLE: begin
				if (in_pend_r) begin
					st_nxt      = PCX_WAIT_CTRL;
					kind_nxt    = `PCX_KIND_INPUT;
					in_pend_nxt = 1'b0;
				end else if (adc_pend_r) begin
					st_nxt       = PCX_WAIT_CTRL;
					kind_nxt     = `PCX_KIND_ADC;
					adc_pend_nxt = 1'b0;
				end
			end
			PCX_WAIT_CTRL: begin
				if (tx_ctrl_sent) begin
					st_nxt   = PCX_SEND;
					data_nxt = (kind_r == `PCX_KIND_ADC) ? {res_r, 6'h00} : pin_s;
				end
			end
			PCX_SEND: begin
				if (kind_r == `PCX_KIND_INPUT) data_nxt = pin_s;
				if (tx_done) begin
					st_nxt    = PCX_IDLE;
					adc_clear = (kind_r == `PCX_KIND_ADC);
				end
			end
		endcase
		if ((rx_valid && rx_remote) || edge_hit || calibrated) in_pend_nxt = 1'b1;
		if (adc_done) adc_pend_nxt = 1'b1;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r       <= PCX_IDLE;
			prev_r     <= '0;
			in_pend_r  <= 1'b0;
			adc_pend_r <= 1'b0;
			kind_r     <= `PCX_KIND_INPUT;
			data_r     <= '0;
			res_r      <= '0;
		end else begin
			st_r       <= st_nxt;
			prev_r     <= pin_s;
			in_pend_r  <= in_pend_nxt;
			adc_pend_r <= adc_pend_nxt;
			kind_r     <= kind_nxt;
			data_r     <= data_nxt;
			res_r      <= res_nxt;
		end
	end

	assign tx_req  = (st_r != PCX_IDLE);
	assign tx_kind = kind_r;
	assign tx_data = data_r;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_out_write;
		wr && rx_byte1 == `PCX_ADDR_DOUT && !dev_reset;
	endsequence

	sequence s_poll;
		rx_valid && rx_remote && st_r == PCX_IDLE && !in_pend_r && !adc_pend_r;
	endsequence

	// the written value is taken from the frame edge, since the bytes may already carry the next frame
	AST_OUT_LOAD: assert property (s_out_write |=> ##1 (port_out & port_oe & ~16'h0790)
		== ($past(wr_val, 2) & port_oe & ~16'h0790))
		else $error("output register not loaded from write frame");
	AST_OE_GATE: assert property (##1 (port_oe == $past(oen_r)))
		else $error("pin enable differs from enable register");
	AST_POLL_ANS: assert property (s_poll |=> in_pend_r ##1 (tx_req && tx_kind == `PCX_KIND_INPUT))
		else $error("remote poll not answered");
	AST_EDGE_REQ: assert property (edge_hit |=> in_pend_r || tx_req)
		else $error("captured edge raised no frame");
	AST_RO_IGNORE: assert property (wr && (rx_byte1 == `PCX_ADDR_DIN || rx_byte1 == `PCX_ADDR_ADC || rx_byte1 > `PCX_ADDR_ADC)
		|=> $stable(dout_r) && $stable(oen_r) && $stable(rise_r) && $stable(fall_r) && $stable(pma_r))
		else $error("read-only or unknown address changed a register");
	AST_SNAP: assert property (st_r == PCX_WAIT_CTRL && tx_ctrl_sent && kind_r == `PCX_KIND_INPUT
		|=> tx_data == $past(pin_s))
		else $error("snapshot not taken at control field");
	AST_TX_LOW: assert property (tx_dominant |=> bus_tx_pull_low_oe && !bus_tx_pull_low_o)
		else $error("first transmit pin not pulled low");
	AST_TX_HIGH: assert property (bus_mode2 |=> !bus_tx_drive_high_oe)
		else $error("second transmit pin driven in bus mode 2");
	AST_SIGNON: assert property (calibrated && st_r == PCX_IDLE |=> in_pend_r ##1 tx_req)
		else $error("no sign-on frame after calibration");
	AST_ID0: assert property (ext_osc_r |-> !id_bits[0] && port_zero_or_clock)
		else $error("pin zero used as identifier in external mode");
endmodule : pcx_port_io
`default_nettype wire

// File: core/pcx_regs.svh
// register addresses, field positions, reset values and pin roles of the port expander
`ifndef PCX_REGS_SVH
`define PCX_REGS_SVH

`define PCX_NUM_PINS      16
`define PCX_ADDR_W        8
`define PCX_ADDR_DIN      8'h00
`define PCX_ADDR_RISE     8'h01
`define PCX_ADDR_FALL     8'h02
`define PCX_ADDR_DOUT     8'h03
`define PCX_ADDR_OEN      8'h04
`define PCX_ADDR_ACFG     8'h05
`define PCX_ADDR_PMA      8'h06
`define PCX_ADDR_PMB      8'h07
`define PCX_ADDR_ADC      8'h08
`define PCX_RST_VAL       16'h0000
`define PCX_ACFG_WMASK    16'hf7e0
`define PCX_PM_WMASK      16'hffc0
`define PCX_ACFG_ADC_BIT  15
`define PCX_ACFG_OC3_BIT  14
`define PCX_ACFG_OC2_BIT  13
`define PCX_ACFG_OC1_BIT  12
`define PCX_ACFG_M2_BIT   9
`define PCX_ACFG_M1_BIT   8
`define PCX_PIN_PMB       4
`define PCX_PIN_CMP1      7
`define PCX_PIN_CMP3      8
`define PCX_PIN_CMP2      9
`define PCX_PIN_PMA       10
`define PCX_PIN_CMPIN     15
`define PCX_KIND_INPUT    1'b0
`define PCX_KIND_ADC      1'b1

`endif

// File: core/pcx_pkg.sv
// types shared by the port expander modules
package pcx_pkg;
	typedef enum logic [1:0] {
		PCX_IDLE      = 2'b00,
		PCX_WAIT_CTRL = 2'b01,
		PCX_SEND      = 2'b11
	} pcx_tx_state_type;
endpackage : pcx_pkg

// File: core/pcx_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pcx_pin_sync #(
	parameter int W = 16
) (
	input  wire logic         clk,       // system clock
	input  wire logic         rst_b,     // async reset, active low
	input  wire logic [W-1:0] pin_in,    // raw pin levels
	output logic      [W-1:0] stable_o   // level accepted once stages agree
);
	logic [W-1:0] s1_r, s2_r, s3_r, st_r, st_nxt;

	// a bit changes only when stages two and three agree; stage one feeds stage two only
	always_comb begin
		st_nxt = st_r;
		for (int i = 0; i < W; i++) begin
			if (s2_r[i] == s3_r[i]) begin
				st_nxt[i] = s3_r[i];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			st_r <= '0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			st_r <= st_nxt;
		end
	end

	assign stable_o = st_r;
endmodule : pcx_pin_sync
`default_nettype wire

// File: core/pcx_bus_drv.sv
// bus transmit pin drivers and device reset source selection
`timescale 1ns/1ps
`default_nettype none
module pcx_bus_drv (
	input  wire logic clk,                  // system clock
	input  wire logic rst_b,                // async reset, active low
	input  wire logic tx_dominant,          // protocol engine sends dominant bit
	input  wire logic bus_mode2,            // bus mode 2 active
	input  wire logic ext_osc,              // latched oscillator mode
	input  wire logic reset_pin_s,          // synced dedicated reset pin
	input  wire logic osc_sel_s,            // synced mode-select / reset pin
	output logic      bus_tx_pull_low_o,    // first transmit pin value
	output logic      bus_tx_pull_low_oe,   // first transmit pin enable
	output logic      bus_tx_drive_high_o,  // second transmit pin value
	output logic      bus_tx_drive_high_oe, // second transmit pin enable
	output logic      dev_reset_o           // device-level reset request
);
	logic pl_oe_r, pl_oe_nxt, dh_oe_r, dh_oe_nxt, dr_r, dr_nxt;

	// open-drain style: only the dominant level is ever driven
	always_comb begin
		pl_oe_nxt = tx_dominant;
		dh_oe_nxt = tx_dominant && !bus_mode2;
		// pin polarity depends on oscillator mode
		dr_nxt = ext_osc ? !osc_sel_s : reset_pin_s;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pl_oe_r <= 1'b0;
			dh_oe_r <= 1'b0;
			dr_r    <= 1'b0;
		end else begin
			pl_oe_r <= pl_oe_nxt;
			dh_oe_r <= dh_oe_nxt;
			dr_r    <= dr_nxt;
		end
	end

	assign bus_tx_pull_low_o    = 1'b0;
	assign bus_tx_pull_low_oe   = pl_oe_r;
	assign bus_tx_drive_high_o  = 1'b1;
	assign bus_tx_drive_high_oe = dh_oe_r;
	assign dev_reset_o          = dr_r;
endmodule : pcx_bus_drv
`default_nettype wire

// File: verification/pcx_host_model.sv
// far-side frame engine model: paces each transmission and records the frame sent
`timescale 1ns/1ps
`default_nettype none
module pcx_host_model (
	input  wire logic        clk,          // system clock
	input  wire logic        rst_b,        // async reset, active low
	input  wire logic        slow,         // long frames when high
	input  wire logic        tx_req,       // frame wanted
	input  wire logic        tx_kind,      // frame kind
	input  wire logic [15:0] tx_data,      // frame contents
	output logic             tx_ctrl_sent, // control field sent pulse
	output logic             tx_done,      // frame finished pulse
	output logic      [7:0]  frames,       // frames received
	output logic      [15:0] last_data,    // contents of last frame
	output logic             last_kind     // kind of last frame
);
	logic        busy_r, busy_nxt, ctl_r, ctl_nxt, done_r, done_nxt, kind_r, kind_nxt;
	logic [5:0]  cnt_r, cnt_nxt, gap;
	logic [7:0]  frm_r, frm_nxt;
	logic [15:0] dat_r, dat_nxt;

	assign gap          = slow ? 6'h14 : 6'h02;
	assign tx_ctrl_sent = ctl_r;
	assign tx_done      = done_r;
	assign frames       = frm_r;
	assign last_data    = dat_r;
	assign last_kind    = kind_r;

	////////////////////////////////////////////////////////////////////////
	// frame pacing; a two-cycle tail lets tx_req fall before a new frame
	always_comb begin
		{busy_nxt, ctl_nxt, done_nxt, cnt_nxt} = {busy_r, 2'b00, cnt_r};
		{kind_nxt, frm_nxt, dat_nxt} = {kind_r, frm_r, dat_r};
		if (!busy_r) begin
			busy_nxt = tx_req;
			cnt_nxt  = 6'h00;
		end else begin
			cnt_nxt  = cnt_r + 6'h01;
			ctl_nxt  = (cnt_r == gap);
			done_nxt = (cnt_r == gap * 6'h02);
			// ordered compare: a change to fast pacing in the tail must not keep the model busy
			busy_nxt = (cnt_r < gap * 6'h02 + 6'h02);
		end
		// contents taken as the frame ends, since they track pins until then
		if (done_r) begin
			frm_nxt  = frm_r + 8'h01;
			dat_nxt  = tx_data;
			kind_nxt = tx_kind;
		end
	end

	// state registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{busy_r, ctl_r, done_r, kind_r, cnt_r, frm_r, dat_r} <= '0;
		end else begin
			{busy_r, ctl_r, done_r, kind_r, cnt_r, frm_r, dat_r} <=
				{busy_nxt, ctl_nxt, done_nxt, kind_nxt, cnt_nxt, frm_nxt, dat_nxt};
		end
	end
endmodule : pcx_host_model
`default_nettype wire

// File: verification/pcx_port_io_tb.sv
// self-checking bench for the port side of the bus-linked expander
`timescale 1ns/1ps
`default_nettype none
`include "pcx_regs.svh"
module pcx_port_io_tb;
	logic        clk, rst_b, rx_valid, rx_remote, calibrated, tx_dominant, bus_mode2, reset_pin;
	logic        pma, pmb, conv_fb, adc_done, slow, tx_req, tx_kind, ctl, done, plo, ploe, dho, dhoe;
	logic        dev_reset, p0clk, cfo, cci, adc_start, last_kind, ext_strap, osc_n;
	logic [15:0] port_in, port_out, port_oe, tx_data, acfg, pm_a, pm_b, last_data;
	logic [7:0]  b1, b2, b3, frames;
	logic [3:0]  id_bits;
	logic [2:0]  cmp;
	logic [9:0]  adc_res;
	int          n_errors, total_checks, cycles, starts;
	logic [15:0] alt_cfg [5] = '{16'h0100, 16'h0200, 16'h1000, 16'h2000, 16'h4000};
	logic [15:0] alt_pin [5] = '{16'h0010, 16'h0400, 16'h0080, 16'h0200, 16'h0100};

	pcx_port_io uut (.clk(clk), .rst_b(rst_b), .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
		.rx_valid(rx_valid), .rx_remote(rx_remote), .rx_byte1(b1), .rx_byte2(b2), .rx_byte3(b3),
		.calibrated(calibrated), .tx_req(tx_req), .tx_kind(tx_kind), .tx_data(tx_data), .tx_ctrl_sent(ctl),
		.tx_done(done), .tx_dominant(tx_dominant), .bus_mode2(bus_mode2), .bus_tx_pull_low_o(plo),
		.bus_tx_pull_low_oe(ploe), .bus_tx_drive_high_o(dho), .bus_tx_drive_high_oe(dhoe),
		.ext_osc_strap(ext_strap), .reset_pin(reset_pin), .osc_select_or_reset_n(osc_n), .dev_reset(dev_reset),
		.port_zero_or_clock(p0clk), .id_bits(id_bits), .pulse_mod_out_a(pma), .pulse_mod_out_b(pmb),
		.cmp_in(cmp), .conv_feedback(conv_fb), .converter_feedback_out(cfo), .conv_cmp_in(cci),
		.analog_cfg(acfg), .pm_a_level(pm_a), .pm_b_level(pm_b), .adc_start(adc_start),
		.adc_done(adc_done), .adc_result(adc_res));

	pcx_host_model host (.clk(clk), .rst_b(rst_b), .slow(slow), .tx_req(tx_req), .tx_kind(tx_kind),
		.tx_data(tx_data), .tx_ctrl_sent(ctl), .tx_done(done), .frames(frames), .last_data(last_data),
		.last_kind(last_kind));

	////////////////////////////////////////////////////////////////////////
	// clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// hang guard and conversion start counter
	always @(posedge clk) begin
		cycles++;
		if (adc_start === 1'b1) starts++;
		if (cycles == 20000) begin
			n_errors++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick

	// one frame held for a single cycle; bytes two and three carry the value
	task automatic send(input logic rem, input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		{rx_valid, rx_remote, b1, b2, b3} = {1'b1, rem, a, d};
		@(negedge clk);
		rx_valid = 1'b0;
	endtask : send

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		send(1'b0, a, d);
	endtask : wr

	// bounded wait for the host to have seen n frames
	task automatic wait_frames(input int n);
		int k;
		k = 0;
		while (frames !== 8'(n) && k < 500) begin
			@(negedge clk);
			k++;
		end
		chk("frame count", 16'(frames), 16'(n));
	endtask : wait_frames

	task conclude;
		$display("errors %0d checks %0d", n_errors, total_checks);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{rst_b, rx_valid, rx_remote, calibrated, tx_dominant, bus_mode2, reset_pin} = '0;
		{pma, pmb, conv_fb, adc_done, slow, b1, b2, b3, cmp, adc_res, port_in, ext_strap, osc_n} = '0;
		tick(16);
		rst_b = 1'b1;
		tick(8);
		chk("oe after reset", port_oe, 16'h0000);
		wr(`PCX_ADDR_OEN, 16'h00ff);
		wr(`PCX_ADDR_DOUT, 16'ha5c3);
		tick(2);
		chk("driven bits", port_out & port_oe, 16'h00c3);
		wr(`PCX_ADDR_OEN, 16'hffff);
		tick(2);
		chk("all driven", port_out, 16'ha5c3);
		wr(`PCX_ADDR_DIN, 16'h1111);
		wr(8'h09, 16'h2222);
		wr(`PCX_ADDR_ADC, 16'h3333);
		tick(3);
		chk("read-only write", port_out, 16'ha5c3);
		chk("no frame", 16'(tx_req), 16'h0000);
		wr(`PCX_ADDR_PMA, 16'hffff);
		tick(2);
		chk("pulse a level", pm_a, 16'hffc0);
		wr(`PCX_ADDR_PMB, 16'h1234);
		tick(2);
		chk("pulse b level", pm_b, 16'h1200);
		// alternate functions: data output 0, every alternate source 1
		wr(`PCX_ADDR_DOUT, 16'h0000);
		{pma, pmb, cmp, conv_fb} = '1;
		for (int i = 0; i < 5; i++) begin
			wr(`PCX_ADDR_ACFG, alt_cfg[i]);
			tick(2);
			chk("alternate pin", port_out, alt_pin[i]);
		end
		chk("feedback out", 16'(cfo), 16'h0001);
		{pma, pmb, cmp, conv_fb} = '0;
		wr(`PCX_ADDR_ACFG, 16'h0000);
		// every combination of bit level and bus mode
		for (int i = 0; i < 4; i++) begin
			{tx_dominant, bus_mode2} = 2'(i);
			tick(2);
			chk("bus pins", {12'h000, ploe, plo, dhoe, dho},
				{12'h000, tx_dominant, 1'b0, tx_dominant & ~bus_mode2, 1'b1});
		end
		{tx_dominant, bus_mode2} = 2'b00;
		port_in = 16'h9234;
		tick(8);
		send(1'b1, 8'h00, 16'h0000);
		wait_frames(1);
		chk("poll data", last_data, 16'h9234);
		chk("poll kind", 16'(last_kind), 16'h0000);
		chk("id bits", {id_bits, 11'h000, p0clk}, 16'h4000);
		chk("cmp pin", 16'(cci), 16'h0001);
		// slow frame: pins change after the control field and must be sent
		slow = 1'b1;
		send(1'b1, 8'h00, 16'h0000);
		for (int k = 0; k < 200 && ctl !== 1'b1; k++) tick(1);
		port_in = 16'h4321;
		wait_frames(2);
		chk("late pins", last_data, 16'h4321);
		slow = 1'b0;
		// edge capture on pin zero with rise only, fall only and both enables set
		port_in = 16'h0000;
		wr(`PCX_ADDR_RISE, 16'h0001);
		tick(8);
		port_in[0] = 1'b1;
		wait_frames(3);
		chk("edge data", last_data, 16'h0001);
		port_in[0] = 1'b0;
		tick(60);
		chk("fall ignored", 16'(frames), 16'h0003);
		wr(`PCX_ADDR_RISE, 16'h0000);
		wr(`PCX_ADDR_FALL, 16'h0001);
		port_in[0] = 1'b1;
		tick(60);
		chk("rise ignored", 16'(frames), 16'h0003);
		port_in[0] = 1'b0;
		wait_frames(4);
		wr(`PCX_ADDR_RISE, 16'h0001);
		port_in[0] = 1'b1;
		wait_frames(5);
		port_in[0] = 1'b0;
		wait_frames(6);
		// sign-on after calibration
		calibrated = 1'b1;
		tick(1);
		calibrated = 1'b0;
		wait_frames(7);
		// conversion result read over the link
		wr(`PCX_ADDR_ACFG, 16'h8000);
		chk("adc start", 16'(starts), 16'h0001);
		{adc_done, adc_res} = {1'b1, 10'h2a5};
		tick(1);
		adc_done = 1'b0;
		wait_frames(8);
		chk("result data", last_data, 16'ha940);
		chk("result kind", 16'(last_kind), 16'h0001);
		tick(4);
		chk("adc bit clear", acfg, 16'h0000);
		// dedicated reset pin is active high in internal oscillator mode
		reset_pin = 1'b1;
		tick(10);
		chk("reset pin", {port_oe[14:0], dev_reset}, 16'h0001);
		reset_pin = 1'b0;
		tick(10);
		chk("reset off", 16'(dev_reset), 16'h0000);
		// second reset into external oscillator mode: select pin is the reset, pin zero the clock
		{ext_strap, osc_n, port_in} = {1'b1, 1'b1, 16'h000f};
		rst_b = 1'b0;
		tick(4);
		rst_b = 1'b1;
		tick(10);
		chk("ext id bits", {id_bits, 11'h000, p0clk}, 16'he001);
		reset_pin = 1'b1;
		tick(10);
		chk("ext reset pin ignored", 16'(dev_reset), 16'h0000);
		osc_n = 1'b0;
		tick(10);
		chk("ext reset low", 16'(dev_reset), 16'h0001);
		conclude();
	end
endmodule : pcx_port_io_tb
`default_nettype wire
